// >>> gpm_pkg.sv
// Constants for the per-pin function multiplexer of eight eight-bit ports
package gpm_pkg;
  localparam int PIN_COUNT  = 8;
  localparam int PORT_COUNT = 8;
  localparam int CODE_W     = 4;
  localparam int ADDR_W     = 8;

  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_DATA      = 8'h00;
  localparam logic [7:0] OFS_DIRECTION = 8'h04;
  localparam logic [7:0] OFS_ALT_SEL   = 8'h08;
  localparam logic [7:0] OFS_DIG_EN    = 8'h0c;
  localparam logic [7:0] OFS_ANA_MODE  = 8'h10;
  localparam logic [7:0] OFS_PULL_UP   = 8'h14;
  localparam logic [7:0] OFS_PULL_DOWN = 8'h18;
  localparam logic [7:0] OFS_PORT_CTL  = 8'h1c;
  localparam logic [7:0] OFS_PIN_STATE = 8'h20;

  // Mux code of the second choice on the debug pins
  localparam logic [3:0] FN1_CODE = 4'h4;

  // Per-port tables, index 0 is port A
  localparam logic [7:0] FN0_MASK [PORT_COUNT] = '{8'hff, 8'h8f, 8'hdf, 8'h0f, 8'h0f, 8'h70, 8'h13, 8'h19};
  localparam logic [7:0] FN1_MASK [PORT_COUNT] = '{8'h00, 8'h00, 8'h0b, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] COMP_MASK [PORT_COUNT] = '{8'h00, 8'h70, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] ISO_MASK [PORT_COUNT] = '{8'h00, 8'h00, 8'h00, 8'hf0, 8'hf0, 8'h00, 8'h00, 8'h00};
  localparam logic [31:0] FN0_CODES [PORT_COUNT] = '{32'h1111_1111, 32'h1111_1111, 32'h1111_3333, 32'h1111_1111,
                                                      32'h1111_1111, 32'h1111_1111, 32'h1111_1111, 32'h1111_1111};

  // Reset defaults
  localparam logic [7:0] RST_ALT_SEL [PORT_COUNT] = '{8'h3f, 8'h0c, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] RST_DIG_EN [PORT_COUNT] = '{8'h3f, 8'h0c, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] RST_PULL_UP [PORT_COUNT] = '{8'h00, 8'h00, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] RST_PULL_DOWN = 8'h00;
  localparam logic [7:0] RST_ANA_MODE  = 8'h00;
  localparam logic [7:0] RST_DIRECTION = 8'h00;
  localparam logic [7:0] RST_DATA      = 8'h00;
  localparam logic [31:0] RST_PORT_CTL [PORT_COUNT] = '{32'h0011_1111, 32'h0000_1100, 32'h0000_3333, 32'h0000_0000,
                                                         32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
endpackage : gpm_pkg

// >>> gpm_pin_if.sv
// Per-pin carrier between the port registers and the pin routing cell
interface gpm_pin_if;
  logic       alt_sel;
  logic       dig_en;
  logic       ana_mode;
  logic       direction;
  logic       data_bit;
  logic [3:0] mux_code;
  logic       has_fn0;
  logic       has_fn1;
  logic [3:0] fn0_code;
  logic       is_iso;
  logic       is_comp;
  logic       fn0_out;
  logic       fn0_oe;
  logic       fn1_out;
  logic       fn1_oe;
  logic       pad_out;
  logic       pad_oe;
  logic       own_fn0;
  logic       own_fn1;
  logic       iso_en;
  logic       comp_en;
  logic       capture;

  modport cfg (output alt_sel, dig_en, ana_mode, direction, data_bit, mux_code, has_fn0, has_fn1, fn0_code,
               is_iso, is_comp, fn0_out, fn0_oe, fn1_out, fn1_oe,
               input pad_out, pad_oe, own_fn0, own_fn1, iso_en, comp_en, capture);
  modport route (input alt_sel, dig_en, ana_mode, direction, data_bit, mux_code, has_fn0, has_fn1, fn0_code,
                 is_iso, is_comp, fn0_out, fn0_oe, fn1_out, fn1_oe,
                 output pad_out, pad_oe, own_fn0, own_fn1, iso_en, comp_en, capture);
endinterface : gpm_pin_if

// >>> gpm_pin_route.sv
// Routing of one pin: port data path, peripheral function or analog path
module gpm_pin_route import gpm_pkg::*; (
  gpm_pin_if.route pin
);
  logic sel_ok;

  assign sel_ok = pin.alt_sel & pin.dig_en;

  assign pin.own_fn0 = sel_ok & pin.has_fn0 & (pin.mux_code == pin.fn0_code);
  assign pin.own_fn1 = sel_ok & pin.has_fn1 & (pin.mux_code == FN1_CODE);

  // peripheral or port drives
  // An unlisted code under alternate select leaves the pin undriven rather than guessing a source
  assign pin.pad_out = pin.own_fn0 ? pin.fn0_out : (pin.own_fn1 ? pin.fn1_out : (~pin.alt_sel & pin.data_bit));
  assign pin.pad_oe  = pin.own_fn0 ? pin.fn0_oe : (pin.own_fn1 ? pin.fn1_oe : (~pin.alt_sel & pin.dig_en & pin.direction));

  assign pin.capture = ~pin.alt_sel & pin.dig_en & ~pin.direction;

  assign pin.iso_en  = pin.is_iso & pin.ana_mode & ~pin.dig_en;
  assign pin.comp_en = pin.is_comp & ~pin.dig_en;

endmodule // gpm_pin_route

// >>> gpm_port.sv
// Function selection, pad control and registers of one eight-bit port

// Behaviour
// - An isolated analog input connects its analog path only with analog mode set and the digital input cut off.
// - A comparator input counts as analog as soon as its digital enable is clear, without analog mode.
// - A peripheral reaches a pin only with alternate select and digital enable set, chosen by the mux code.
// - Each pin's select, enable and mux code settings affect that pin alone.
// - After reset, ordinary pins are plain tri-stated port pins with all their settings at zero.
// - Power-on reset and the external reset pin both restore every pin's defaults.
// - Port A bits 5:0 and port B bits 3:2 reset to their serial function with code 0x1 and pulls off.
// - Port C bits 3:0 reset to the debug function, pull-up on, pull-down off, code 0x3.
// - A pin offers only its own listed functions, port C bits 0, 1 and 3 offering two choices.
// - With alternate select and digital enable set the peripheral chosen by the mux code controls the pin; with alternate select clear the data register does.
// - With alternate select clear and digital enable set, a direction bit of 0 captures the pin into the data register, 1 drives the data bit out.
module gpm_port import gpm_pkg::*; #(
  parameter int PORT_INDEX = 0
) (
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire logic [ADDR_W-1:0]   reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [31:0]         reg_rdata,
  input  wire logic [PIN_COUNT-1:0] pad_in,
  output logic      [PIN_COUNT-1:0] pad_out,
  output logic      [PIN_COUNT-1:0] pad_oe,
  output logic      [PIN_COUNT-1:0] pad_pull_up,
  output logic      [PIN_COUNT-1:0] pad_pull_down,
  output logic      [PIN_COUNT-1:0] pad_input_en,
  output logic      [PIN_COUNT-1:0] iso_analog_en,
  output logic      [PIN_COUNT-1:0] comp_analog_en,
  input  wire logic [PIN_COUNT-1:0] fn0_out,
  input  wire logic [PIN_COUNT-1:0] fn0_oe,
  input  wire logic [PIN_COUNT-1:0] fn1_out,
  input  wire logic [PIN_COUNT-1:0] fn1_oe,
  output logic      [PIN_COUNT-1:0] fn0_owned,
  output logic      [PIN_COUNT-1:0] fn1_owned,
  output logic      [PIN_COUNT-1:0] periph_in
);

  generate
    if (PORT_INDEX < 0 || PORT_INDEX >= PORT_COUNT) begin : g_bad_port
      $error("gpm_port: PORT_INDEX out of range");
    end
  endgenerate

  localparam int PI = (PORT_INDEX >= 0 && PORT_INDEX < PORT_COUNT) ? PORT_INDEX : 0;

  // Configuration state
  logic [7:0]  data_reg;
  logic [7:0]  direction_reg;
  logic [7:0]  alt_function_select_reg;
  logic [7:0]  digital_enable_reg;
  logic [7:0]  analog_mode_select_reg;
  logic [7:0]  pull_up_enable_reg;
  logic [7:0]  pull_down_enable_reg;
  logic [31:0] port_control_reg;

  logic [7:0]  next_data_reg;
  logic [7:0]  next_direction_reg;
  logic [7:0]  next_alt_function_select_reg;
  logic [7:0]  next_digital_enable_reg;
  logic [7:0]  next_analog_mode_select_reg;
  logic [7:0]  next_pull_up_enable_reg;
  logic [7:0]  next_pull_down_enable_reg;
  logic [31:0] next_port_control_reg;
  logic [31:0] next_reg_rdata;

  // Per-pin results from the routing cells
  logic [7:0] r_pad_out;
  logic [7:0] r_pad_oe;
  logic [7:0] r_own0;
  logic [7:0] r_own1;
  logic [7:0] r_iso;
  logic [7:0] r_comp;
  logic [7:0] r_capture;

  // Checker view of the mux code fields, decoded apart from the routing cells
  logic [7:0] code_hit0;
  logic [7:0] code_hit1;

  generate
    for (genvar k = 0; k < PIN_COUNT; k++) begin : g_pin
      gpm_pin_if u_bus ();
      assign u_bus.alt_sel   = alt_function_select_reg[k];
      assign u_bus.dig_en    = digital_enable_reg[k];
      assign u_bus.ana_mode  = analog_mode_select_reg[k];
      assign u_bus.direction = direction_reg[k];
      assign u_bus.data_bit  = data_reg[k];
      assign u_bus.mux_code  = port_control_reg[4*k +: CODE_W];
      assign u_bus.fn0_code  = FN0_CODES[PI][4*k +: CODE_W];
      assign u_bus.has_fn0   = FN0_MASK[PI][k];
      assign u_bus.has_fn1   = FN1_MASK[PI][k];
      assign u_bus.is_iso    = ISO_MASK[PI][k];
      assign u_bus.is_comp   = COMP_MASK[PI][k];
      assign u_bus.fn0_out   = fn0_out[k];
      assign u_bus.fn0_oe    = fn0_oe[k];
      assign u_bus.fn1_out   = fn1_out[k];
      assign u_bus.fn1_oe    = fn1_oe[k];
      assign r_pad_out[k]    = u_bus.pad_out;
      assign r_pad_oe[k]     = u_bus.pad_oe;
      assign r_own0[k]       = u_bus.own_fn0;
      assign r_own1[k]       = u_bus.own_fn1;
      assign r_iso[k]        = u_bus.iso_en;
      assign r_comp[k]       = u_bus.comp_en;
      assign r_capture[k]    = u_bus.capture;
      assign code_hit0[k]    = (port_control_reg[4*k +: CODE_W] == FN0_CODES[PI][4*k +: CODE_W]);
      assign code_hit1[k]    = (port_control_reg[4*k +: CODE_W] == FN1_CODE);
      gpm_pin_route u_route (
        .pin (u_bus.route)
      );
    end
  endgenerate

  // Register writes and input capture
  always_comb begin
    next_direction_reg           = direction_reg;
    next_alt_function_select_reg = alt_function_select_reg;
    next_digital_enable_reg      = digital_enable_reg;
    next_analog_mode_select_reg  = analog_mode_select_reg;
    next_pull_up_enable_reg      = pull_up_enable_reg;
    next_pull_down_enable_reg    = pull_down_enable_reg;
    next_port_control_reg        = port_control_reg;
    next_data_reg                = data_reg;
    if (reg_wr) begin
      if (reg_addr == OFS_DATA) begin
        next_data_reg = reg_wdata[7:0];
      end else if (reg_addr == OFS_DIRECTION) begin
        next_direction_reg = reg_wdata[7:0];
      end else if (reg_addr == OFS_ALT_SEL) begin
        next_alt_function_select_reg = reg_wdata[7:0];
      end else if (reg_addr == OFS_DIG_EN) begin
        next_digital_enable_reg = reg_wdata[7:0];
      end else if (reg_addr == OFS_ANA_MODE) begin
        next_analog_mode_select_reg = reg_wdata[7:0];
      end else if (reg_addr == OFS_PULL_UP) begin
        next_pull_up_enable_reg = reg_wdata[7:0];
      end else if (reg_addr == OFS_PULL_DOWN) begin
        next_pull_down_enable_reg = reg_wdata[7:0];
      end else if (reg_addr == OFS_PORT_CTL) begin
        next_port_control_reg = reg_wdata;
      end
    end
    // capture beats a write
    // Input bits follow the pin, so a software write there is overwritten in the same cycle
    next_data_reg = (next_data_reg & ~r_capture) | (pad_in & r_capture);
  end

  // Read port
  always_comb begin
    next_reg_rdata = 32'h0000_0000;
    if (reg_rd) begin
      if (reg_addr == OFS_DATA) begin
        next_reg_rdata = {24'h00_0000, data_reg};
      end else if (reg_addr == OFS_DIRECTION) begin
        next_reg_rdata = {24'h00_0000, direction_reg};
      end else if (reg_addr == OFS_ALT_SEL) begin
        next_reg_rdata = {24'h00_0000, alt_function_select_reg};
      end else if (reg_addr == OFS_DIG_EN) begin
        next_reg_rdata = {24'h00_0000, digital_enable_reg};
      end else if (reg_addr == OFS_ANA_MODE) begin
        next_reg_rdata = {24'h00_0000, analog_mode_select_reg};
      end else if (reg_addr == OFS_PULL_UP) begin
        next_reg_rdata = {24'h00_0000, pull_up_enable_reg};
      end else if (reg_addr == OFS_PULL_DOWN) begin
        next_reg_rdata = {24'h00_0000, pull_down_enable_reg};
      end else if (reg_addr == OFS_PORT_CTL) begin
        next_reg_rdata = port_control_reg;
      end else if (reg_addr == OFS_PIN_STATE) begin
        next_reg_rdata = {24'h00_0000, pad_in};
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      data_reg                <= RST_DATA;
      direction_reg           <= RST_DIRECTION;
      alt_function_select_reg <= RST_ALT_SEL[PI];
      digital_enable_reg      <= RST_DIG_EN[PI];
      analog_mode_select_reg  <= RST_ANA_MODE;
      pull_up_enable_reg      <= RST_PULL_UP[PI];
      pull_down_enable_reg    <= RST_PULL_DOWN;
      port_control_reg        <= RST_PORT_CTL[PI];
      reg_rdata               <= 32'h0000_0000;
    end else begin
      data_reg                <= next_data_reg;
      direction_reg           <= next_direction_reg;
      alt_function_select_reg <= next_alt_function_select_reg;
      digital_enable_reg      <= next_digital_enable_reg;
      analog_mode_select_reg  <= next_analog_mode_select_reg;
      pull_up_enable_reg      <= next_pull_up_enable_reg;
      pull_down_enable_reg    <= next_pull_down_enable_reg;
      port_control_reg        <= next_port_control_reg;
      reg_rdata               <= next_reg_rdata;
    end
  end

  // Pad outputs registered; they lag the configuration by one cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      pad_out        <= 8'h00;
      pad_oe         <= 8'h00;
      pad_pull_up    <= 8'h00;
      pad_pull_down  <= 8'h00;
      pad_input_en   <= 8'h00;
      iso_analog_en  <= 8'h00;
      comp_analog_en <= 8'h00;
      fn0_owned      <= 8'h00;
      fn1_owned      <= 8'h00;
      periph_in      <= 8'h00;
    end else begin
      pad_out        <= r_pad_out;
      pad_oe         <= r_pad_oe;
      pad_pull_up    <= pull_up_enable_reg;
      pad_pull_down  <= pull_down_enable_reg;
      pad_input_en   <= digital_enable_reg;
      iso_analog_en  <= r_iso;
      comp_analog_en <= r_comp;
      fn0_owned      <= r_own0;
      fn1_owned      <= r_own1;
      periph_in      <= pad_in & digital_enable_reg;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_iso_analog_gate: assert property (
    !$past(rst) |-> iso_analog_en == ($past(analog_mode_select_reg) & ~$past(digital_enable_reg) & ISO_MASK[PI]))
    else $error("isolated analog path wrong");
  a_comp_direct_path: assert property (
    !$past(rst) |-> comp_analog_en == (~$past(digital_enable_reg) & COMP_MASK[PI]))
    else $error("comparator path wrong");
  a_alt_needs_enables: assert property (
    ((fn0_owned | fn1_owned) & ~($past(alt_function_select_reg) & $past(digital_enable_reg))) == 8'h00)
    else $error("peripheral owns pin without select and enable");
  a_reset_defaults: assert property (
    $past(rst) |-> alt_function_select_reg == RST_ALT_SEL[PI] && port_control_reg == RST_PORT_CTL[PI]
                   && direction_reg == 8'h00 && pull_down_enable_reg == 8'h00)
    else $error("reset defaults wrong");
  a_reset_pulls_quiet: assert property (
    $past(rst) ##1 !$past(rst) |-> (pad_oe & ~RST_ALT_SEL[PI]) == 8'h00 ##0 pad_pull_up == RST_PULL_UP[PI])
    else $error("pull or drive after reset wrong");
  a_only_listed_fn: assert property (
    (fn0_owned & ~FN0_MASK[PI]) == 8'h00 && (fn1_owned & ~FN1_MASK[PI]) == 8'h00)
    else $error("unlisted function selected");
  a_port_mode_drive: assert property (
    !$past(rst) |-> (pad_oe & ~$past(alt_function_select_reg) & ~$past(direction_reg)) == 8'h00)
    else $error("input pin driven in port mode");
  a_input_capture: assert property (
    !$past(rst) |-> ((data_reg ^ $past(pad_in)) & $past(r_capture)) == 8'h00)
    else $error("input not captured");

  // Decode cross-checks: owner bits against the raw fields one edge earlier
  a_fn0_decode: assert property (
    !$past(rst) |-> fn0_owned == ($past(alt_function_select_reg) & $past(digital_enable_reg)
                                  & $past(code_hit0) & FN0_MASK[PI]))
    else $error("first function decode wrong");
  a_fn1_decode: assert property (
    !$past(rst) |-> fn1_owned == ($past(alt_function_select_reg) & $past(digital_enable_reg)
                                  & $past(code_hit1) & FN1_MASK[PI]))
    else $error("second function decode wrong");
  // Pins owned by the first function must show the peripheral's level and enable, never the data bit
  a_alt_drive_follows: assert property (
    !$past(rst) |-> ((pad_out ^ $past(fn0_out)) & fn0_owned) == 8'h00
                    && ((pad_oe ^ $past(fn0_oe)) & fn0_owned) == 8'h00)
    else $error("owned pin not driven by its peripheral");
  a_port_drive_value: assert property (
    !$past(rst) |-> ((pad_out ^ $past(data_reg)) & pad_oe & ~fn0_owned & ~fn1_owned) == 8'h00)
    else $error("port pin drives wrong level");
  a_pulls_follow: assert property (
    !$past(rst) |-> pad_pull_up == $past(pull_up_enable_reg) && pad_pull_down == $past(pull_down_enable_reg))
    else $error("pull controls lag wrong");
  a_input_follows: assert property (
    !$past(rst) |-> pad_input_en == $past(digital_enable_reg) && (pad_input_en & iso_analog_en) == 8'h00)
    else $error("digital input not cut off");
  // Ordinary pins come out of either reset plain and tri-stated
  a_plain_after_reset: assert property (
    $past(rst) |-> digital_enable_reg == RST_DIG_EN[PI] && pull_up_enable_reg == RST_PULL_UP[PI]
                   && analog_mode_select_reg == 8'h00 && data_reg == 8'h00 && reg_rdata == 32'h0000_0000)
    else $error("plain pin settings wrong after reset");
  // A full-word write must land every field, not only the low pins
  a_ctl_write_lands: assert property (
    !$past(rst) && $past(reg_wr) && $past(reg_addr) == OFS_PORT_CTL |-> port_control_reg == $past(reg_wdata))
    else $error("port control write lost");
  // Read data stand one cycle only, so a late sampler sees zero
  a_read_idle_zero: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside its cycle");

  c_alt_owned: cover property (|fn0_owned);
  c_second_choice: cover property (|fn1_owned);
  c_port_drive: cover property (|(pad_oe & ~fn0_owned & ~fn1_owned));
  c_analog_iso: cover property (|iso_analog_en);
  c_comparator: cover property (|comp_analog_en);

endmodule // gpm_port

// >>> gpm_periph_model.sv
// Far side of one port: peripheral function drives and the package pins
module gpm_periph_model (
  input  wire logic       clock,
  input  wire logic [7:0] fn_val,
  input  wire logic [7:0] ext_drive,
  input  wire logic [7:0] ext_level,
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe,
  input  wire logic [7:0] pull_up,
  input  wire logic [7:0] pull_down,
  output logic      [7:0] pad_in,
  output logic      [7:0] fn0_out,
  output logic      [7:0] fn0_oe,
  output logic      [7:0] fn1_out,
  output logic      [7:0] fn1_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  // An undriven pin without a pull must not settle to a steady level
  logic [7:0] float_bits = 8'h55;

  always @(posedge clock) begin
    float_bits <= ~float_bits;
  end

  // Second function drives the inverse so the two choices stay distinguishable
  always_comb begin
    fn0_out = fn_val;
    fn0_oe = 8'hff;
    fn1_out = ~fn_val;
    fn1_oe = 8'hff;
    for (int k = 0; k < 8; k++) begin
      pad_in[k] = pad_oe[k] ? pad_out[k] : ext_drive[k] ? ext_level[k] :
                  pull_up[k] ? 1'b1 : pull_down[k] ? 1'b0 : float_bits[k];
    end
  end
endmodule // gpm_periph_model

// >>> tb.sv
// Self-checking bench for ports A to D of the pin function multiplexer
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import gpm_pkg::*;

  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [7:0]  fn_val = 8'ha5;
  logic [7:0]  ext_drive = 8'h00;
  logic [7:0]  ext_level = 8'h00;
  logic [31:0] rdata [4];
  logic [7:0]  pin_in [4], pout [4], poe [4], pup [4], pdn [4], ien [4], iso [4], comp [4];
  logic [7:0]  f0o [4], f0e [4], f1o [4], f1e [4], own0 [4], own1 [4], pin_per [4];
  int          error_cnt = 0;
  int          checked = 0;

  always #25 clock = ~clock;

  for (genvar g = 0; g < 4; g++) begin : g_port
    gpm_port #(.PORT_INDEX(g)) i_gpm_port (
      .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(rdata[g]), .pad_in(pin_in[g]), .pad_out(pout[g]), .pad_oe(poe[g]),
      .pad_pull_up(pup[g]), .pad_pull_down(pdn[g]), .pad_input_en(ien[g]), .iso_analog_en(iso[g]),
      .comp_analog_en(comp[g]), .fn0_out(f0o[g]), .fn0_oe(f0e[g]), .fn1_out(f1o[g]), .fn1_oe(f1e[g]),
      .fn0_owned(own0[g]), .fn1_owned(own1[g]), .periph_in(pin_per[g])
    );
    gpm_periph_model i_gpm_periph_model (
      .clock(clock), .fn_val(fn_val), .ext_drive(ext_drive), .ext_level(ext_level), .pad_out(pout[g]),
      .pad_oe(poe[g]), .pull_up(pup[g]), .pull_down(pdn[g]), .pad_in(pin_in[g]), .fn0_out(f0o[g]),
      .fn0_oe(f0e[g]), .fn1_out(f1o[g]), .fn1_oe(f1e[g])
    );
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // All ports share the bus, so one write configures every port alike
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input int p, input logic [7:0] a, input logic [31:0] exp, input string name);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk(name, exp, rdata[p]);
  endtask

  // Pad outputs follow a register write by two edges
  task automatic settle;
    repeat (2) @(posedge clock);
    #1;
  endtask

  task automatic complete_run;
    $display("Counts: %0d comparisons, %0d mismatches", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rd(0, OFS_ALT_SEL, 32'h3f, "a_alt_sel");
    rd(0, OFS_PORT_CTL, 32'h0011_1111, "a_port_ctl");
    rd(1, OFS_DIG_EN, 32'h0c, "b_dig_en");
    rd(1, OFS_PORT_CTL, 32'h0000_1100, "b_port_ctl");
    rd(1, OFS_PULL_UP, 32'h00, "b_pull_up");
    rd(2, OFS_ALT_SEL, 32'h0f, "c_alt_sel");
    rd(2, OFS_DIG_EN, 32'h0f, "c_dig_en");
    rd(2, OFS_PULL_UP, 32'h0f, "c_pull_up");
    rd(2, OFS_PULL_DOWN, 32'h00, "c_pull_down");
    rd(2, OFS_PORT_CTL, 32'h0000_3333, "c_port_ctl");
    rd(3, OFS_ALT_SEL, 32'h00, "d_alt_sel");
    rd(3, OFS_DIG_EN, 32'h00, "d_dig_en");
    rd(3, OFS_PORT_CTL, 32'h00, "d_port_ctl");
    rd(3, OFS_DIRECTION, 32'h00, "d_direction");
    rd(3, 8'h40, 32'h00, "unmapped");
    chk("a_own0", 8'h3f, own0[0]);
    chk("b_own0", 8'h0c, own0[1]);
    chk("c_own0", 8'h0f, own0[2]);
    chk("c_pad_oe", 8'h0f, poe[2]);
    chk("c_pad_out", 8'h05, pout[2] & 8'h0f);
    chk("c_pad_pull_up", 8'h0f, pup[2]);
    chk("d_pad_oe", 8'h00, poe[3]);
    $display("test reset defaults done");
    wr(OFS_ALT_SEL, 32'h1f);
    wr(OFS_DIG_EN, 32'h1d);
    wr(OFS_PORT_CTL, 32'h0001_3334);
    settle;
    chk("c_own0", 8'h1c, own0[2]);
    chk("c_own1", 8'h01, own1[2]);
    chk("c_pad_oe", 8'h1d, poe[2]);
    chk("c_pad_out", 8'h04, pout[2] & 8'h1d);
    wr(OFS_ALT_SEL, 32'h3f);
    wr(OFS_DIG_EN, 32'h3f);
    wr(OFS_PORT_CTL, 32'h0010_3433);
    rd(2, OFS_PORT_CTL, 32'h0010_3433, "c_port_ctl");
    settle;
    chk("c_own0", 8'h0b, own0[2]);
    chk("c_own1", 8'h00, own1[2]);
    chk("c_pad_oe", 8'h0b, poe[2]);
    $display("test function routing done");
    wr(OFS_ALT_SEL, 32'h40);
    wr(OFS_DIG_EN, 32'h40);
    for (int c = 0; c < 16; c++) begin
      wr(OFS_PORT_CTL, {4'h0, c[3:0], 24'h0});
      settle;
      chk("c_own0_pin6", (c == 1) ? 8'h40 : 8'h00, own0[2]);
    end
    $display("test mux codes done");
    wr(OFS_ALT_SEL, 32'h00);
    wr(OFS_DIG_EN, 32'hff);
    wr(OFS_DIRECTION, 32'hf0);
    ext_drive <= 8'h0f;
    ext_level <= 8'h0c;
    wr(OFS_DATA, 32'ha5);
    settle;
    chk("c_pad_oe", 8'hf0, poe[2]);
    chk("c_pad_out", 8'ha0, pout[2] & 8'hf0);
    chk("c_own0", 8'h00, own0[2]);
    chk("c_periph_in", 8'hac, pin_per[2]);
    rd(2, OFS_DATA, 32'hac, "c_data");
    rd(2, OFS_PIN_STATE, 32'hac, "c_pin_state");
    $display("test port mode done");
    wr(OFS_DIG_EN, 32'h00);
    wr(OFS_ANA_MODE, 32'h9f);
    settle;
    chk("c_comp", 8'h20, comp[2]);
    chk("b_comp", 8'h70, comp[1]);
    chk("d_iso", 8'h90, iso[3]);
    chk("c_iso", 8'h00, iso[2]);
    chk("d_input_en", 8'h00, ien[3]);
    wr(OFS_DIG_EN, 32'h80);
    settle;
    chk("d_iso", 8'h10, iso[3]);
    wr(OFS_DIG_EN, 32'h20);
    settle;
    chk("c_comp", 8'h00, comp[2]);
    chk("b_comp", 8'h50, comp[1]);
    $display("test analog modes done");
    wr(OFS_PULL_DOWN, 32'hff);
    settle;
    chk("c_pad_pull_down", 8'hff, pdn[2]);
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rd(2, OFS_ALT_SEL, 32'h0f, "c_alt_sel");
    rd(2, OFS_PORT_CTL, 32'h0000_3333, "c_port_ctl");
    rd(2, OFS_PULL_DOWN, 32'h00, "c_pull_down");
    rd(3, OFS_ANA_MODE, 32'h00, "d_ana_mode");
    rd(0, OFS_PORT_CTL, 32'h0011_1111, "a_port_ctl");
    settle;
    chk("c_pad_pull_down", 8'h00, pdn[2]);
    chk("c_own0", 8'h0f, own0[2]);
    $display("test second reset done");
    complete_run;
  end

  // The tests need well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    $display("[FAIL] watchdog expected finish seen timeout");
    complete_run;
  end
endmodule // tb
